// file: cmp_pkg.sv
package cmp_pkg;

	localparam int unsigned XLEN = 32;
	localparam int unsigned EXC_NUM_W = 6;
	localparam int unsigned TICK_W = 24;
	localparam int unsigned MPU_MAX_REGIONS = 8;

	localparam logic [31:0] BOOT_SP_ADDR = 32'h0000_0000;
	localparam logic [31:0] BOOT_PC_ADDR = 32'h0000_0004;
	localparam logic [31:0] STACK_WORD = 32'h0000_0004;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	localparam logic [1:0] CONTROL_RESET = 2'h0;
	localparam logic PRIORITY_MASK_REG_RESET = 1'b0;
	localparam logic [EXC_NUM_W-1:0] EXC_NUM_RESET = 6'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	localparam int unsigned CTRL_NPRIV_BIT = 0;
	localparam int unsigned CTRL_SPSEL_BIT = 1;
	localparam int unsigned PRIORITY_MASK_REG_BIT = 0;
	localparam int unsigned FLAGS_LSB = 28;
	localparam int unsigned TICK_FLAG_BIT = 16;
	localparam int unsigned TICK_EN_BIT = 0;

	localparam logic [3:0] GPR_SP_IDX = 4'hd;
	localparam logic [3:0] GPR_PC_IDX = 4'hf;

	localparam logic [1:0] TICK_CTRL_OFS = 2'h0;
	localparam logic [1:0] TICK_RELOAD_OFS = 2'h1;
	localparam logic [1:0] TICK_CURRENT_OFS = 2'h2;

	typedef enum logic [3:0]
	{
		SR_CONDITION_FLAGS_REG,
		SR_ACTIVE_EXCEPTION_NUMBER,
		SR_EXECUTION_STATE_REG,
		SR_PSR,
		SR_IEPSR,
		SR_IAPSR,
		SR_EAPSR,
		SR_MSP,
		SR_PSP,
		SR_PRIORITY_MASK_REG,
		SR_CONTROL
	} cmp_sreg_type;

	typedef enum logic [1:0]
	{
		PR_TICK,
		PR_INTC,
		PR_SYSCTL,
		PR_NONE
	} cmp_periph_type;

endpackage

// file: cmp_tick_timer.sv
`timescale 1ns/1ps
`default_nettype none

module cmp_tick_timer
	import cmp_pkg::*;
#(
	parameter int unsigned WIDTH = TICK_W
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [1:0] ofs,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata_r,
	output logic tick_event
);

	logic enable_r;
	logic flag_r;
	logic [WIDTH-1:0] reload_r;
	logic [WIDTH-1:0] current_r;
	logic wrap;

	assign wrap = enable_r && (current_r == '0);
	assign tick_event = wrap;

	// Down counter; reaching zero reloads on the next edge.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			current_r <= '0;
		else if (wr_en && ofs == TICK_CURRENT_OFS)
			current_r <= '0;
		else if (wrap)
			current_r <= reload_r;
		else if (enable_r)
			current_r <= current_r - 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			enable_r <= 1'b0;
			reload_r <= '0;
		end
		else if (wr_en && ofs == TICK_CTRL_OFS)
			enable_r <= wdata[TICK_EN_BIT];
		else if (wr_en && ofs == TICK_RELOAD_OFS)
			reload_r <= wdata[WIDTH-1:0];
	end

	// A wrap in the same cycle as the clearing read keeps the flag set.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			flag_r <= 1'b0;
		else if (wrap)
			flag_r <= 1'b1;
		else if (rd_en && ofs == TICK_CTRL_OFS)
			flag_r <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			rdata_r <= WORD_ZERO;
		else if (rd_en)
		begin
			case (ofs)
				TICK_CTRL_OFS: rdata_r <= (32'(flag_r) << TICK_FLAG_BIT) | 32'(enable_r);
				TICK_RELOAD_OFS: rdata_r <= 32'(reload_r);
				TICK_CURRENT_OFS: rdata_r <= 32'(current_r);
				default: rdata_r <= WORD_ZERO;
			endcase
		end
	end

endmodule

`default_nettype wire

// file: cmp_core_state.sv
`timescale 1ns/1ps
`default_nettype none

module cmp_core_state
	import cmp_pkg::*;
#(
	parameter int unsigned MPU_REGIONS = MPU_MAX_REGIONS
)
(
	input wire logic sys_clk,
	input wire logic reset,
	output logic mem_re,
	output logic mem_we,
	output logic [31:0] mem_addr_r,
	output logic [31:0] mem_wdata_r,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ready,
	output logic core_ready,
	input wire logic gpr_we,
	input wire logic [3:0] gpr_widx,
	input wire logic [31:0] gpr_wdata,
	input wire logic [3:0] gpr_ridx,
	output logic [31:0] gpr_rdata_r,
	input wire logic sreg_we,
	input wire logic sreg_re,
	input wire cmp_sreg_type sreg_sel,
	input wire logic [31:0] sreg_wdata,
	output logic [31:0] sreg_rdata_r,
	input wire logic flags_we,
	input wire logic [3:0] flags_val,
	input wire logic exec_state_we,
	input wire logic exec_state_val,
	input wire logic cps_req,
	input wire logic cps_disable,
	input wire logic exc_enter,
	input wire logic [EXC_NUM_W-1:0] exc_num,
	input wire logic exc_finish_all,
	input wire logic svc_exec,
	output logic svc_call_r,
	input wire logic push_req,
	input wire logic [31:0] push_data,
	output logic push_busy,
	input wire logic periph_req,
	input wire logic periph_we,
	input wire cmp_periph_type periph_region,
	input wire logic [1:0] periph_ofs,
	input wire logic [31:0] periph_wdata,
	output logic periph_grant,
	output logic periph_fault,
	output logic [31:0] periph_rdata,
	output logic tick_event,
	output logic handler_mode,
	output logic priv_level,
	output logic [31:0] active_stack_pointer,
	output logic [EXC_NUM_W-1:0] active_exception_number,
	output logic priority_mask,
	output logic exec_state_bit,
	output logic [3:0] mpu_region_count
);

	typedef enum logic [1:0]
	{
		ST_BOOT_SP,
		ST_BOOT_PC,
		ST_RUN,
		ST_PUSH
	} cmp_state_type;

	cmp_state_type state_r;
	logic [31:0] main_stack_pointer_r;
	logic [31:0] process_stack_pointer_r;
	logic [31:0] gpr_r [0:15];
	logic [1:0] control_r;
	logic priority_mask_reg_r;
	logic [EXC_NUM_W-1:0] exc_num_r;
	logic [3:0] flags_r;
	logic t_bit_r;
	logic use_psp;
	logic push_go;
	logic [31:0] push_sp_nxt;
	logic sp_gpr_wr;
	logic sreg_priv_wr;
	logic tick_wr;
	logic tick_rd;

	localparam int unsigned MPU_EFF = (MPU_REGIONS > MPU_MAX_REGIONS) ? MPU_MAX_REGIONS
		: MPU_REGIONS;

	function automatic logic [31:0] align_word(input logic [31:0] v);
		align_word = {v[31:2], 2'b00};
	endfunction

	function automatic logic sel_has_flags(input cmp_sreg_type s);
		sel_has_flags = (s == SR_CONDITION_FLAGS_REG) || (s == SR_PSR) || (s == SR_IAPSR) || (s == SR_EAPSR);
	endfunction

	function automatic logic sel_has_exc(input cmp_sreg_type s);
		sel_has_exc = (s == SR_ACTIVE_EXCEPTION_NUMBER) || (s == SR_PSR) || (s == SR_IEPSR) || (s == SR_IAPSR);
	endfunction

	assign mpu_region_count = 4'(MPU_EFF);

	assign handler_mode = (exc_num_r != EXC_NUM_RESET);
	assign priv_level = handler_mode || !control_r[CTRL_NPRIV_BIT];
	assign use_psp = !handler_mode && control_r[CTRL_SPSEL_BIT];
	assign active_stack_pointer = use_psp ? process_stack_pointer_r
		: main_stack_pointer_r;
	assign active_exception_number = exc_num_r;
	assign priority_mask = priority_mask_reg_r;
	assign exec_state_bit = t_bit_r;
	assign core_ready = (state_r == ST_RUN);
	assign push_busy = (state_r != ST_RUN);
	assign push_go = (state_r == ST_RUN) && push_req;
	assign push_sp_nxt = active_stack_pointer - STACK_WORD;
	assign mem_re = (state_r == ST_BOOT_SP) || (state_r == ST_BOOT_PC);
	assign mem_we = (state_r == ST_PUSH);
	assign sp_gpr_wr = gpr_we && (gpr_widx == GPR_SP_IDX);
	assign sreg_priv_wr = sreg_we && priv_level;

	// Supervisor call is honoured at any privilege level.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			svc_call_r <= 1'b0;
		else
			svc_call_r <= svc_exec && (state_r == ST_RUN);
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_r <= ST_BOOT_SP;
			mem_addr_r <= BOOT_SP_ADDR;
			mem_wdata_r <= WORD_ZERO;
		end
		else
		begin
			case (state_r)
				ST_BOOT_SP:
					if (mem_ready)
					begin
						state_r <= ST_BOOT_PC;
						mem_addr_r <= BOOT_PC_ADDR;
					end
				ST_BOOT_PC:
					if (mem_ready)
						state_r <= ST_RUN;
				ST_RUN:
					if (push_go)
					begin
						state_r <= ST_PUSH;
						mem_addr_r <= push_sp_nxt;
						mem_wdata_r <= push_data;
					end
				ST_PUSH:
					if (mem_ready)
						state_r <= ST_RUN;
				default:
					state_r <= ST_BOOT_SP;
			endcase
		end
	end

	// A push owns the stack pointer in its cycle; a same-cycle register write to it is lost.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			main_stack_pointer_r <= WORD_ZERO;
		else if (state_r == ST_BOOT_SP && mem_ready)
			main_stack_pointer_r <= align_word(mem_rdata);
		else if (push_go && !use_psp)
			main_stack_pointer_r <= push_sp_nxt;
		else if (sp_gpr_wr && !use_psp)
			main_stack_pointer_r <= align_word(gpr_wdata);
		else if (sreg_priv_wr && sreg_sel == SR_MSP)
			main_stack_pointer_r <= align_word(sreg_wdata);
	end

	// The process stack pointer has no defined reset value, so it is left unreset.
	always_ff @(posedge sys_clk)
	begin
		if (push_go && use_psp)
			process_stack_pointer_r <= push_sp_nxt;
		else if (sp_gpr_wr && use_psp)
			process_stack_pointer_r <= align_word(gpr_wdata);
		else if (sreg_priv_wr && sreg_sel == SR_PSP)
			process_stack_pointer_r <= align_word(sreg_wdata);
	end

	always_ff @(posedge sys_clk)
	begin
		if (state_r == ST_BOOT_PC && mem_ready)
			gpr_r[GPR_PC_IDX] <= {mem_rdata[31:1], 1'b0};
		else if (gpr_we && gpr_widx != GPR_SP_IDX)
			gpr_r[gpr_widx] <= gpr_wdata;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			gpr_rdata_r <= WORD_ZERO;
		else if (gpr_ridx == GPR_SP_IDX)
			gpr_rdata_r <= active_stack_pointer;
		else
			gpr_rdata_r <= gpr_r[gpr_ridx];
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			t_bit_r <= 1'b0;
		else if (state_r == ST_BOOT_PC && mem_ready)
			t_bit_r <= mem_rdata[0];
		else if (exec_state_we)
			t_bit_r <= exec_state_val;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			control_r <= CONTROL_RESET;
		else if (sreg_priv_wr && sreg_sel == SR_CONTROL)
			control_r <= sreg_wdata[1:0];
	end

	// Mask changes from unprivileged code are dropped silently.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			priority_mask_reg_r <= PRIORITY_MASK_REG_RESET;
		else if (cps_req && priv_level)
			priority_mask_reg_r <= cps_disable;
		else if (sreg_priv_wr && sreg_sel == SR_PRIORITY_MASK_REG)
			priority_mask_reg_r <= sreg_wdata[PRIORITY_MASK_REG_BIT];
	end

	// Entry wins over a same-cycle finish, since a new exception keeps handler mode alive.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			exc_num_r <= EXC_NUM_RESET;
		else if (exc_enter && exc_num != EXC_NUM_RESET)
			exc_num_r <= exc_num;
		else if (exc_finish_all)
			exc_num_r <= EXC_NUM_RESET;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			flags_r <= FLAGS_RESET;
		else if (flags_we)
			flags_r <= flags_val;
		else if (sreg_we && sel_has_flags(sreg_sel))
			flags_r <= sreg_wdata[31:FLAGS_LSB];
	end

	// Execution state always reads as zero; exception number is never writable here.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			sreg_rdata_r <= WORD_ZERO;
		else if (sreg_re)
		begin
			sreg_rdata_r <= WORD_ZERO;
			if (sel_has_flags(sreg_sel))
				sreg_rdata_r[31:FLAGS_LSB] <= flags_r;
			if (sel_has_exc(sreg_sel))
				sreg_rdata_r[EXC_NUM_W-1:0] <= exc_num_r;
			if (sreg_sel == SR_CONTROL)
				sreg_rdata_r[1:0] <= control_r;
			if (priv_level && sreg_sel == SR_PRIORITY_MASK_REG)
				sreg_rdata_r[PRIORITY_MASK_REG_BIT] <= priority_mask_reg_r;
			if (priv_level && sreg_sel == SR_MSP)
				sreg_rdata_r <= main_stack_pointer_r;
			if (priv_level && sreg_sel == SR_PSP)
				sreg_rdata_r <= process_stack_pointer_r;
		end
	end

	assign periph_grant = periph_req && priv_level && (periph_region != PR_NONE);
	assign periph_fault = periph_req && !priv_level && (periph_region != PR_NONE);
	assign tick_wr = periph_grant && periph_we && (periph_region == PR_TICK);
	assign tick_rd = periph_grant && !periph_we && (periph_region == PR_TICK);

	cmp_tick_timer #(
		.WIDTH(TICK_W)
	) u_tick (
		.sys_clk(sys_clk),
		.reset(reset),
		.wr_en(tick_wr),
		.rd_en(tick_rd),
		.ofs(periph_ofs),
		.wdata(periph_wdata),
		.rdata_r(periph_rdata),
		.tick_event(tick_event)
	);

	a_reset_clears: assert property (@(posedge sys_clk) disable iff (reset)
		$past(reset) |-> (exc_num_r == EXC_NUM_RESET) && (control_r == CONTROL_RESET)
			&& !priority_mask_reg_r && !handler_mode)
		else $error("reset did not clear mode, control and mask");

	a_thread_exit: assert property (@(posedge sys_clk) disable iff (reset)
		exc_finish_all && !exc_enter |=> !handler_mode && priv_level == !control_r[0])
		else $error("finishing exceptions did not return to thread mode");

	a_handler_priv: assert property (@(posedge sys_clk) disable iff (reset)
		handler_mode |-> priv_level && periph_grant == (periph_req && periph_region != PR_NONE))
		else $error("handler mode lost privilege");

	a_ctrl_guard: assert property (@(posedge sys_clk) disable iff (reset)
		sreg_we && sreg_sel == SR_CONTROL && !priv_level |=> $stable(control_r))
		else $error("unprivileged write changed control");

	a_periph_block: assert property (@(posedge sys_clk) disable iff (reset)
		periph_req && !priv_level && periph_region == PR_TICK |-> periph_fault && !tick_wr)
		else $error("unprivileged peripheral access not blocked");

	a_cps_unpriv: assert property (@(posedge sys_clk) disable iff (reset)
		cps_req && !priv_level |=> priority_mask_reg_r == $past(priority_mask_reg_r))
		else $error("unprivileged state change masked interrupts");

	a_svc_call: assert property (@(posedge sys_clk) disable iff (reset)
		svc_exec && core_ready && !priv_level |=> svc_call_r)
		else $error("supervisor call not raised");

	a_push_order: assert property (@(posedge sys_clk) disable iff (reset)
		push_go |=> mem_we && (mem_addr_r == $past(active_stack_pointer) - STACK_WORD)
			&& (mem_addr_r == active_stack_pointer || $past(use_psp) != use_psp))
		else $error("push did not decrement before writing");

	a_handler_msp: assert property (@(posedge sys_clk) disable iff (reset)
		handler_mode |-> active_stack_pointer == main_stack_pointer_r)
		else $error("handler mode not on main stack");

	a_boot_sp: assert property (@(posedge sys_clk) disable iff (reset)
		state_r == ST_BOOT_SP && mem_ready |=> main_stack_pointer_r
			== ($past(mem_rdata) & ~32'h0000_0003) && mem_addr_r == BOOT_PC_ADDR)
		else $error("main stack pointer not loaded from address zero");

	a_boot_pc: assert property (@(posedge sys_clk) disable iff (reset)
		state_r == ST_BOOT_PC && mem_ready |=> core_ready && t_bit_r == $past(mem_rdata[0]))
		else $error("reset vector not loaded");

endmodule

`default_nettype wire

// file: tb_core_mode_privilege_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_core_mode_privilege_regs
	import cmp_pkg::*;
;
	logic sys_clk, reset, mem_re, mem_we, mem_ready, core_ready, gpr_we, sreg_we, sreg_re;
	logic flags_we, exec_state_we, exec_state_val, cps_req, cps_disable, exc_enter;
	logic exc_finish_all, svc_exec, svc_call_r, push_req, push_busy, periph_req, periph_we;
	logic periph_grant, periph_fault, tick_event, handler_mode, priv_level, priority_mask;
	logic exec_state_bit;
	logic [31:0] mem_addr_r, mem_wdata_r, mem_rdata, gpr_wdata, gpr_rdata_r, sreg_wdata;
	logic [31:0] sreg_rdata_r, push_data, periph_wdata, periph_rdata, active_stack_pointer;
	logic [3:0] gpr_widx, gpr_ridx, flags_val, mpu_region_count;
	logic [1:0] periph_ofs;
	logic [EXC_NUM_W-1:0] exc_num, active_exception_number;
	cmp_sreg_type sreg_sel;
	cmp_periph_type periph_region;
	int failures, check_count, cycles, seen;

	cmp_core_state DUT (.sys_clk, .reset, .mem_re, .mem_we, .mem_addr_r, .mem_wdata_r,
		.mem_rdata, .mem_ready, .core_ready, .gpr_we, .gpr_widx, .gpr_wdata, .gpr_ridx,
		.gpr_rdata_r, .sreg_we, .sreg_re, .sreg_sel, .sreg_wdata, .sreg_rdata_r, .flags_we,
		.flags_val, .exec_state_we, .exec_state_val, .cps_req, .cps_disable, .exc_enter,
		.exc_num, .exc_finish_all, .svc_exec, .svc_call_r, .push_req, .push_data,
		.push_busy, .periph_req, .periph_we, .periph_region, .periph_ofs, .periph_wdata,
		.periph_grant, .periph_fault, .periph_rdata, .tick_event, .handler_mode,
		.priv_level, .active_stack_pointer, .active_exception_number, .priority_mask,
		.exec_state_bit, .mpu_region_count);

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task end_of_test;
		$display("failures=%0d check_count=%0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// All tasks start and end just after a falling edge.
	task sw(input cmp_sreg_type s, input logic [31:0] d);
		sreg_sel = s;
		sreg_wdata = d;
		sreg_we = 1'b1;
		@(negedge sys_clk);
		sreg_we = 1'b0;
		@(negedge sys_clk);
	endtask

	task sr(input cmp_sreg_type s, input logic [31:0] exp);
		sreg_sel = s;
		sreg_re = 1'b1;
		@(negedge sys_clk);
		sreg_re = 1'b0;
		chk(sreg_rdata_r, exp);
		@(negedge sys_clk);
	endtask

	task mem_ans(input logic [31:0] d);
		int n;
		n = 0;
		while (!(mem_re === 1'b1 || mem_we === 1'b1) && n < 20)
		begin
			@(negedge sys_clk);
			n++;
		end
		mem_rdata = d;
		mem_ready = 1'b1;
		@(negedge sys_clk);
		mem_ready = 1'b0;
		// A released data bus must not keep showing the last word.
		mem_rdata = ~d;
	endtask

	task push(input logic [31:0] d, input logic [31:0] sp);
		int n;
		push_data = d;
		push_req = 1'b1;
		@(negedge sys_clk);
		push_req = 1'b0;
		chk(active_stack_pointer, sp);
		chk(mem_addr_r, sp);
		chk(mem_we, 1'b1);
		chk(mem_wdata_r, d);
		mem_ans(32'h0);
		n = 0;
		while (push_busy !== 1'b0 && n < 20)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk(push_busy, 1'b0);
	endtask

	task ex(input logic [EXC_NUM_W-1:0] num);
		exc_num = num;
		exc_enter = 1'b1;
		@(negedge sys_clk);
		exc_enter = 1'b0;
		@(negedge sys_clk);
	endtask

	task fin;
		exc_finish_all = 1'b1;
		@(negedge sys_clk);
		exc_finish_all = 1'b0;
		@(negedge sys_clk);
	endtask

	task change_proc_state_instr(input logic dis);
		cps_req = 1'b1;
		cps_disable = dis;
		@(negedge sys_clk);
		cps_req = 1'b0;
		@(negedge sys_clk);
	endtask

	task pa(input logic we, input cmp_periph_type r, input logic [1:0] o,
		input logic [31:0] d, input logic g);
		periph_req = 1'b1;
		periph_we = we;
		periph_region = r;
		periph_ofs = o;
		periph_wdata = d;
		#1;
		chk(periph_grant, g);
		chk(periph_fault, !g);
		@(negedge sys_clk);
		periph_req = 1'b0;
		@(negedge sys_clk);
	endtask

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			failures++;
			$display("BAD %0t run did not finish", $time);
			end_of_test;
		end
	end

	initial
	begin
		{reset, mem_ready, gpr_we, sreg_we, sreg_re, flags_we, exec_state_we} = 7'h7f;
		{mem_ready, gpr_we, sreg_we, sreg_re, flags_we, exec_state_we} = 6'h00;
		{exec_state_val, cps_req, cps_disable, exc_enter, exc_finish_all} = 5'h00;
		{svc_exec, push_req, periph_req, periph_we} = 4'h0;
		{mem_rdata, gpr_wdata, sreg_wdata, push_data, periph_wdata} = '0;
		{gpr_widx, gpr_ridx, flags_val, periph_ofs, exc_num} = '0;
		sreg_sel = SR_CONDITION_FLAGS_REG;
		periph_region = PR_NONE;
		repeat (20) @(negedge sys_clk);
		chk(handler_mode, 1'b0);
		chk(active_exception_number, 6'h00);
		chk(priority_mask, 1'b0);
		chk({mem_re, core_ready}, 2'h2);
		chk(mem_addr_r, BOOT_SP_ADDR);
		reset = 1'b0;
		mem_ans(32'h2000_1003);
		chk(mem_addr_r, BOOT_PC_ADDR);
		mem_ans(32'h0000_0101);
		chk(core_ready, 1'b1);
		chk(exec_state_bit, 1'b1);
		chk(active_stack_pointer, 32'h2000_1000);
		sr(SR_CONTROL, 32'h0);
		sr(SR_PRIORITY_MASK_REG, 32'h0);
		sr(SR_EXECUTION_STATE_REG, 32'h0);
		chk(mpu_region_count, 4'h8);
		chk(priv_level, 1'b1);
		gpr_we = 1'b1;
		gpr_widx = 4'h5;
		gpr_wdata = 32'h1234_5678;
		@(negedge sys_clk);
		gpr_widx = GPR_SP_IDX;
		gpr_wdata = 32'h2000_2002;
		gpr_ridx = 4'h5;
		@(negedge sys_clk);
		gpr_we = 1'b0;
		chk(gpr_rdata_r, 32'h1234_5678);
		chk(active_stack_pointer, 32'h2000_2000);
		push(32'h0bad_f00d, 32'h2000_1ffc);
		push(32'h5a5a_0001, 32'h2000_1ff8);
		sw(SR_PSP, 32'h3000_0007);
		sr(SR_PSP, 32'h3000_0004);
		sw(SR_CONTROL, 32'h2);
		chk(active_stack_pointer, 32'h3000_0004);
		sr(SR_MSP, 32'h2000_1ff8);
		push(32'h0000_00aa, 32'h3000_0000);
		ex(6'd11);
		chk(handler_mode, 1'b1);
		chk(active_stack_pointer, 32'h2000_1ff8);
		sw(SR_ACTIVE_EXCEPTION_NUMBER, 32'h0);
		sr(SR_ACTIVE_EXCEPTION_NUMBER, 32'd11);
		fin;
		chk(handler_mode, 1'b0);
		chk(active_stack_pointer, 32'h3000_0000);
		sw(SR_CONDITION_FLAGS_REG, 32'ha000_0000);
		sr(SR_CONDITION_FLAGS_REG, 32'ha000_0000);
		flags_we = 1'b1;
		flags_val = 4'h5;
		@(negedge sys_clk);
		flags_we = 1'b0;
		sr(SR_CONDITION_FLAGS_REG, 32'h5000_0000);
		change_proc_state_instr(1'b1);
		chk(priority_mask, 1'b1);
		change_proc_state_instr(1'b0);
		chk(priority_mask, 1'b0);
		pa(1'b1, PR_TICK, TICK_RELOAD_OFS, 32'h3, 1'b1);
		pa(1'b1, PR_TICK, TICK_CTRL_OFS, 32'h1, 1'b1);
		seen = 0;
		repeat (10)
		begin
			@(negedge sys_clk);
			if (tick_event === 1'b1)
				seen++;
		end
		chk(seen > 0, 1'b1);
		pa(1'b0, PR_TICK, TICK_CTRL_OFS, 32'h0, 1'b1);
		chk(periph_rdata[TICK_FLAG_BIT], 1'b1);
		pa(1'b0, PR_INTC, 2'h0, 32'h0, 1'b1);
		sw(SR_CONTROL, 32'h3);
		chk(priv_level, 1'b0);
		sw(SR_CONTROL, 32'h0);
		sr(SR_CONTROL, 32'h3);
		change_proc_state_instr(1'b1);
		chk(priority_mask, 1'b0);
		sr(SR_MSP, 32'h0);
		pa(1'b0, PR_TICK, 2'h0, 32'h0, 1'b0);
		pa(1'b1, PR_INTC, 2'h0, 32'h0, 1'b0);
		pa(1'b0, PR_SYSCTL, 2'h0, 32'h0, 1'b0);
		svc_exec = 1'b1;
		@(negedge sys_clk);
		svc_exec = 1'b0;
		chk(svc_call_r, 1'b1);
		@(negedge sys_clk);
		chk(svc_call_r, 1'b0);
		ex(6'd3);
		chk(priv_level, 1'b1);
		sw(SR_CONTROL, 32'h0);
		fin;
		chk(priv_level, 1'b1);
		chk(active_stack_pointer, 32'h2000_1ff8);
		reset = 1'b1;
		repeat (2) @(negedge sys_clk);
		reset = 1'b0;
		chk({handler_mode, priority_mask, mem_re}, 3'h1);
		sr(SR_CONTROL, 32'h0);
		end_of_test;
	end
endmodule

`default_nettype wire
